// ---- pitmr_top.sv ----
// top of the 8-bit interval timer; source clocks arrive as pins and are synchronised
// assumes a single-cycle strobe register port and a 200 MHz clk much faster than the sources
`timescale 1ns/1ps
`default_nettype none
`include "pitmr_defs.svh"

module pitmr_top
    import pitmr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic main_divided_clock,
    input wire logic low_power_osc_clock,
    input wire logic idle_mode,
    input wire pitmr_pkg::pitmr_byte_t reg_addr,
    input wire pitmr_pkg::pitmr_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pitmr_pkg::pitmr_byte_t reg_rdata,
    output logic tick_irq,
    output logic compare_irq,
    output logic wake_request
);
    import pitmr_pkg::*;

    pitmr_byte_t control;
    pitmr_byte_t tick_count_value;
    pitmr_byte_t compare_point;
    pitmr_byte_t irq_ctl;
    logic tick_event_flag;
    logic compare_match_flag;
    logic [1:0] main_sync;
    logic [1:0] lp_sync;
    logic src_prev;
    logic timer_source_clock;
    logic src_pulse;
    logic divided_tick;
    logic enable_rise;
    logic div_clear;
    logic wr_control;
    logic wr_count;
    logic wr_compare;
    logic wr_irq;
    logic wr_status;
    logic timer_enable_bit;
    logic global_irq_enable;
    logic tick_irq_enable;
    logic compare_irq_enable;
    pitmr_byte_t next_count;
    logic enabled_d;

    assign wr_control = reg_wr && (reg_addr == `PITMR_OFS_CONTROL);
    assign wr_count = reg_wr && (reg_addr == `PITMR_OFS_COUNT);
    assign wr_compare = reg_wr && (reg_addr == `PITMR_OFS_COMPARE);
    assign wr_irq = reg_wr && (reg_addr == `PITMR_OFS_IRQ);
    assign wr_status = reg_wr && (reg_addr == `PITMR_OFS_STATUS);
    assign timer_enable_bit = control[`PITMR_CTL_ENABLE];
    assign global_irq_enable = irq_ctl[`PITMR_IRQ_GLOBAL];
    assign tick_irq_enable = irq_ctl[`PITMR_IRQ_TICK_EN];
    assign compare_irq_enable = irq_ctl[`PITMR_IRQ_CMP_EN];

    // ----------------------------------------
    // source clock selection and synchronisers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            main_sync <= 2'h0;
            lp_sync <= 2'h0;
            src_prev <= 1'b0;
        end else begin
            main_sync <= {main_sync[0], main_divided_clock};
            lp_sync <= {lp_sync[0], low_power_osc_clock};
            src_prev <= timer_source_clock;
        end
    end

    // switching source may give one spurious edge; software should clear the dividers after it
    assign timer_source_clock = control[`PITMR_CTL_SRCSEL] ? lp_sync[1] : main_sync[1];
    // idle_mode is deliberately not a gate here: the timer keeps running in idle
    assign src_pulse = timer_source_clock && !src_prev;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control <= `PITMR_RST_CONTROL;
            enabled_d <= 1'b0;
        end else begin
            enabled_d <= timer_enable_bit;
            if (wr_control) begin
                control <= reg_wdata;
            end else begin
                control[`PITMR_CTL_DIVCLR] <= 1'b0;
            end
        end
    end

    assign enable_rise = timer_enable_bit && !enabled_d;
    assign div_clear = control[`PITMR_CTL_DIVCLR] || enable_rise;

    pitmr_divider u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(timer_enable_bit),
        .clear(div_clear),
        .src_pulse(src_pulse),
        .post_sel(control[`PITMR_CTL_POST_HI:`PITMR_CTL_POST_LO]),
        .tick(divided_tick)
    );

    // ----------------------------------------
    // count value
    // ----------------------------------------
    // wraps naturally from 8'hFF to 8'h00
    assign next_count = tick_count_value + 8'h01;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_count_value <= `PITMR_RST_COUNT;
        end else if (!timer_enable_bit || enable_rise || wr_count) begin
            tick_count_value <= 8'h00;
        end else if (divided_tick) begin
            tick_count_value <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compare_point <= `PITMR_RST_COMPARE;
        end else if (wr_compare) begin
            compare_point <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_ctl <= `PITMR_RST_IRQ;
        end else if (wr_irq) begin
            irq_ctl <= reg_wdata;
        end
    end

    // ----------------------------------------
    // event flags: write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_event_flag <= 1'b0;
            compare_match_flag <= 1'b0;
        end else begin
            if (divided_tick && timer_enable_bit && !wr_count && !enable_rise) begin
                tick_event_flag <= 1'b1;
            end else if (wr_status && reg_wdata[`PITMR_ST_TICK]) begin
                tick_event_flag <= 1'b0;
            end
            if (divided_tick && timer_enable_bit && !wr_count && !enable_rise && next_count == compare_point) begin
                compare_match_flag <= 1'b1;
            end else if (wr_status && reg_wdata[`PITMR_ST_CMP]) begin
                compare_match_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // interrupt outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_irq <= 1'b0;
            compare_irq <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            tick_irq <= tick_event_flag && tick_irq_enable && global_irq_enable;
            compare_irq <= compare_match_flag && compare_irq_enable && global_irq_enable;
            // wake needs no global enable so a sleeping core can be roused
            wake_request <= compare_match_flag && compare_irq_enable;
        end
    end

    // ----------------------------------------
    // read port: reads never touch state
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PITMR_OFS_CONTROL: reg_rdata <= control;
                `PITMR_OFS_COUNT: reg_rdata <= tick_count_value;
                `PITMR_OFS_COMPARE: reg_rdata <= compare_point;
                `PITMR_OFS_IRQ: reg_rdata <= irq_ctl;
                `PITMR_OFS_STATUS: reg_rdata <= {6'h00, compare_match_flag, tick_event_flag};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_disable_write;
        wr_control && !reg_wdata[`PITMR_CTL_ENABLE];
    endsequence

    sequence s_divclr_write;
        wr_control && reg_wdata[`PITMR_CTL_DIVCLR];
    endsequence

    // a second clear strobe right behind the first re-arms the bit, so only a lone strobe is judged
    sequence s_divclr_alone;
        s_divclr_write ##1 !(wr_control && reg_wdata[`PITMR_CTL_DIVCLR]);
    endsequence

    a_count_disable_zero: assert property (@(posedge clk) disable iff (sys_rst)
        s_disable_write |=> ##1 (tick_count_value == 8'h00))
        else $error("count not zero after disable");
    a_count_write_clear: assert property (@(posedge clk) disable iff (sys_rst)
        wr_count |=> (tick_count_value == 8'h00))
        else $error("count write did not clear");
    a_tick_increment: assert property (@(posedge clk) disable iff (sys_rst)
        (divided_tick && timer_enable_bit && !wr_count && !enable_rise) |=>
            (tick_count_value == $past(tick_count_value) + 8'h01) && tick_event_flag)
        else $error("tick did not increment count");
    a_count_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (!divided_tick && !wr_count && !enable_rise && timer_enable_bit && $past(timer_enable_bit)) |=>
            $stable(tick_count_value))
        else $error("count changed without tick");
    a_divclr_self: assert property (@(posedge clk) disable iff (sys_rst)
        s_divclr_alone |=> !control[`PITMR_CTL_DIVCLR])
        else $error("divider clear bit stuck");
    a_compare_set: assert property (@(posedge clk) disable iff (sys_rst)
        (divided_tick && timer_enable_bit && !wr_count && !enable_rise && next_count == compare_point) |=>
            compare_match_flag)
        else $error("compare flag not set");
    a_tick_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
        tick_irq |-> $past(tick_event_flag && tick_irq_enable && global_irq_enable))
        else $error("tick irq without enables");
    a_cmp_irq_gate: assert property (@(posedge clk) disable iff (sys_rst)
        compare_irq |-> $past(compare_match_flag && compare_irq_enable && global_irq_enable))
        else $error("compare irq without enables");
    a_wake_match: assert property (@(posedge clk) disable iff (sys_rst)
        (compare_match_flag && compare_irq_enable) |=> wake_request)
        else $error("wake not raised");
    a_compare_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr_compare |=> (compare_point == $past(reg_wdata)))
        else $error("compare point not written");

    // ----------------------------------------
    // checks on causes and gating
    // ----------------------------------------
    a_count_held_off: assert property (@(posedge clk) disable iff (sys_rst)
        !timer_enable_bit |=> (tick_count_value == 8'h00))
        else $error("count not held at zero while stopped");
    a_enable_restart: assert property (@(posedge clk) disable iff (sys_rst)
        enable_rise |=> (tick_count_value == 8'h00))
        else $error("count not cleared on enable");
    a_tick_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(tick_event_flag) |-> $past(divided_tick && timer_enable_bit))
        else $error("tick flag set without a divider tick");
    a_cmp_flag_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(compare_match_flag) |-> $past(divided_tick && (next_count == compare_point)))
        else $error("compare flag set without a match");

    a_tick_irq_on: assert property (@(posedge clk) disable iff (sys_rst)
        (tick_event_flag && tick_irq_enable && global_irq_enable) |=> tick_irq)
        else $error("tick irq missing");
    a_cmp_irq_on: assert property (@(posedge clk) disable iff (sys_rst)
        (compare_match_flag && compare_irq_enable && global_irq_enable) |=> compare_irq)
        else $error("compare irq missing");
    a_wake_gate: assert property (@(posedge clk) disable iff (sys_rst)
        wake_request |-> $past(compare_match_flag && compare_irq_enable))
        else $error("wake without enabled match");
    a_count_readback: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && (reg_addr == `PITMR_OFS_COUNT)) |=> (reg_rdata == $past(tick_count_value)))
        else $error("count read returned a wrong value");

    // right after a source switch the edge detector still holds the old source, so skip that cycle
    a_src_select: assert property (@(posedge clk) disable iff (sys_rst)
        ($stable(control[`PITMR_CTL_SRCSEL]) && src_pulse) |->
            (control[`PITMR_CTL_SRCSEL] ? $rose(lp_sync[1]) : $rose(main_sync[1])))
        else $error("source edge taken from the wrong clock");
    a_idle_counts: assert property (@(posedge clk) disable iff (sys_rst)
        (idle_mode && divided_tick && timer_enable_bit && !wr_count && !enable_rise) |=>
            (tick_count_value == $past(tick_count_value) + 8'h01))
        else $error("count stalled in idle");
    // too far away for a short run, but guards the wrap if the count ever gets there
    a_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (divided_tick && timer_enable_bit && !wr_count && !enable_rise && (tick_count_value == 8'hFF)) |=>
            (tick_count_value == 8'h00))
        else $error("count did not wrap to zero");
endmodule // pitmr_top
`default_nettype wire

// ---- pitmr_defs.svh ----
// register offsets, field positions, reset values and timing constants of the interval timer
// assumes inclusion by bare name from the package and the design modules
`ifndef PITMR_DEFS_SVH
`define PITMR_DEFS_SVH

`define PITMR_OFS_CONTROL 8'h68
`define PITMR_OFS_COUNT 8'h69
`define PITMR_OFS_COMPARE 8'h6A
`define PITMR_OFS_IRQ 8'h6B
`define PITMR_OFS_STATUS 8'h6C

`define PITMR_CTL_ENABLE 7
`define PITMR_CTL_DIVCLR 6
`define PITMR_CTL_SRCSEL 5
`define PITMR_CTL_POST_HI 4
`define PITMR_CTL_POST_LO 2

`define PITMR_IRQ_GLOBAL 7
`define PITMR_IRQ_CMP_EN 1
`define PITMR_IRQ_TICK_EN 0

`define PITMR_ST_CMP 1
`define PITMR_ST_TICK 0

`define PITMR_RST_CONTROL 8'h00
`define PITMR_RST_COUNT 8'h00
`define PITMR_RST_COMPARE 8'h00
`define PITMR_RST_IRQ 8'h00

`define PITMR_PRE_DIV 256
`define PITMR_PRE_W 8
`define PITMR_POST_W 8

`endif

// ---- pitmr_pkg.sv ----
// types shared by the interval timer modules
// assumes pitmr_defs.svh is on the include path
`include "pitmr_defs.svh"

package pitmr_pkg;
    typedef logic [7:0] pitmr_byte_t;
    typedef logic [2:0] pitmr_postsel_t;
endpackage

// ---- pitmr_divider.sv ----
// two-stage tick divider: fixed pre-divider then selectable power-of-two post-divider
// assumes a source enable pulse, already synchronised, one cycle per source clock edge
`timescale 1ns/1ps
`default_nettype none
`include "pitmr_defs.svh"

module pitmr_divider
    import pitmr_pkg::*;
#(
    parameter int PRE_W = `PITMR_PRE_W,
    parameter int POST_W = `PITMR_POST_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic clear,
    input wire logic src_pulse,
    input wire pitmr_pkg::pitmr_postsel_t post_sel,
    output logic tick
);
    logic [PRE_W-1:0] pre_cnt;
    logic [POST_W-1:0] post_cnt;
    logic [POST_W-1:0] post_last;
    logic pre_wrap;

    // ----------------------------------------
    // pre-divider
    // ----------------------------------------
    assign pre_wrap = src_pulse && (pre_cnt == {PRE_W{1'b1}});

    always_ff @(posedge clk) begin
        if (sys_rst || clear || !run) begin
            pre_cnt <= '0;
        end else if (src_pulse) begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // post-divider
    // ----------------------------------------
    // terminal count is 2^(code+1)-1
    assign post_last = POST_W'((2 << post_sel) - 1);

    always_ff @(posedge clk) begin
        if (sys_rst || clear || !run) begin
            post_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_wrap) begin
                if (post_cnt >= post_last) begin
                    post_cnt <= '0;
                    tick <= 1'b1;
                end else begin
                    post_cnt <= post_cnt + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_div_clear: assert property (@(posedge clk) disable iff (sys_rst)
        (clear || !run) |=> ((pre_cnt == '0) && (post_cnt == '0) && !tick))
        else $error("divider not cleared");
    a_tick_on_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        tick |-> $past(pre_wrap))
        else $error("tick without pre-divider wrap");
endmodule // pitmr_divider
`default_nettype wire

// ---- pitmr_top_tb_top.sv ----
// self-checking bench for the 8-bit interval timer, driving every port directly
// assumes pitmr_defs.svh on the include path and the design files compiled first
`timescale 1ns/1ps
`default_nettype none
`include "pitmr_defs.svh"

module pitmr_top_tb_top;
    import pitmr_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic mdc = 1'b0;
    logic lpc = 1'b0;
    logic idle_mode = 1'b0;
    pitmr_byte_t reg_addr = 8'h00;
    pitmr_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    pitmr_byte_t reg_rdata;
    logic tick_irq;
    logic compare_irq;
    logic wake_request;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    pitmr_top u_dut (.clk(clk), .sys_rst(sys_rst), .main_divided_clock(mdc), .low_power_osc_clock(lpc),
        .idle_mode(idle_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tick_irq(tick_irq), .compare_irq(compare_irq), .wake_request(wake_request));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input pitmr_byte_t seen, input pitmr_byte_t exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input pitmr_byte_t a, input pitmr_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rchk(input pitmr_byte_t a, input pitmr_byte_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    function automatic int div_of(input int sel);
        return 256 << (sel + 1);
    endfunction

    // n rising edges on the chosen source; the other source runs twice as fast to expose a wrong pick
    task automatic pulses(input int n, input logic s);
        for (int c = 0; c < n * 4; c++) begin
            @(posedge clk);
            mdc <= s ? c[0] : c[1];
            lpc <= s ? c[1] : c[0];
        end
        @(posedge clk);
        mdc <= 1'b0;
        lpc <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            finish_test();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [2:0] sel;
        logic s;
        pitmr_byte_t v;
        void'($urandom(32'h5b8595e9));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 8'h68; a <= 8'h6C; a++) begin
            rchk(a[7:0], 8'h00);
        end
        rchk(8'h7F, 8'h00);
        v = pitmr_byte_t'($urandom);
        wr(`PITMR_OFS_COMPARE, v);
        rchk(`PITMR_OFS_COMPARE, v);
        for (int k = 0; k < 8; k++) begin
            wr(`PITMR_OFS_CONTROL, {3'b001, k[2:0], 2'b00});
            rchk(`PITMR_OFS_CONTROL, {3'b001, k[2:0], 2'b00});
        end
        wr(`PITMR_OFS_COMPARE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            s = i[0];
            sel = {1'b0, i[1:0]};
            idle_mode <= 1'($urandom);
            wr(`PITMR_OFS_STATUS, 8'h03);
            wr(`PITMR_OFS_CONTROL, {2'b10, s, sel, 2'b00});
            pulses(div_of(int'(sel)) - 1, s);
            rchk(`PITMR_OFS_COUNT, 8'h00);
            rchk(`PITMR_OFS_STATUS, 8'h00);
            pulses(1, s);
            rchk(`PITMR_OFS_COUNT, 8'h01);
            rchk(`PITMR_OFS_COUNT, 8'h01);
            rchk(`PITMR_OFS_STATUS, 8'h03);
            for (int j = 0; j < 8; j++) begin
                wr(`PITMR_OFS_IRQ, {j[2], 5'b00000, j[1:0]});
                repeat (2) @(posedge clk);
                #1;
                check({7'h00, tick_irq}, {7'h00, j[2] & j[0]});
                check({7'h00, compare_irq}, {7'h00, j[2] & j[1]});
                check({7'h00, wake_request}, {7'h00, j[1]});
            end
            wr(`PITMR_OFS_CONTROL, 8'h00);
            rchk(`PITMR_OFS_COUNT, 8'h00);
        end
        // a partial divider phase must not survive a stop and restart
        wr(`PITMR_OFS_CONTROL, 8'h80);
        pulses(300, 1'b0);
        wr(`PITMR_OFS_CONTROL, 8'h00);
        wr(`PITMR_OFS_CONTROL, 8'h80);
        pulses(511, 1'b0);
        rchk(`PITMR_OFS_COUNT, 8'h00);
        pulses(1, 1'b0);
        rchk(`PITMR_OFS_COUNT, 8'h01);
        pulses(300, 1'b0);
        wr(`PITMR_OFS_CONTROL, 8'hC0);
        @(posedge clk);
        rchk(`PITMR_OFS_CONTROL, 8'h80);
        pulses(511, 1'b0);
        rchk(`PITMR_OFS_COUNT, 8'h01);
        pulses(1, 1'b0);
        rchk(`PITMR_OFS_COUNT, 8'h02);
        wr(`PITMR_OFS_COUNT, pitmr_byte_t'($urandom) | 8'h01);
        rchk(`PITMR_OFS_COUNT, 8'h00);
        pulses(512, 1'b0);
        rchk(`PITMR_OFS_COUNT, 8'h01);
        finish_test();
    end
endmodule // pitmr_top_tb_top

`default_nettype wire
